//--- verification/crs_range_sva.sv
// checker: port-level assertions for the comparator range bank
`timescale 1ns/1ps
`default_nettype none
module crs_range_sva
   import crs_pkg::*;
(
   input wire logic              mclk,
   input wire logic              reset_n,
   input wire logic [CRS_AW-1:0] addr,
   input wire logic [CRS_DW-1:0] wr_data,
   input wire logic              wr_strobe,
   input wire logic              rd_strobe,
   input wire logic [CRS_DW-1:0] rd_data,
   input wire logic              upper_password_level,
   input wire logic              nv_commit,
   input wire logic              nv_commit_sel,
   input wire logic [CRS_DW-1:0] nv_commit_data,
   input wire logic [CRS_CW-1:0] drive_current_range,
   input wire logic [CRS_CW-1:0] power_loop_range,
   input wire logic [CRS_CW-1:0] loss_low_range,
   input wire logic [CRS_MW-1:0] drive_current_fs_mv,
   input wire logic [CRS_MW-1:0] power_loop_fs_mv,
   input wire logic [CRS_MW-1:0] loss_low_fs_mv,
   input wire logic [CRS_PW-1:0] range_percent
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // tables indexed by range code, millivolts and hundredths of a percent
   localparam logic [11:0] DRV_MV [8] = '{12'h4e2, 12'h3e8, 12'h341, 12'h271,
                                         12'h1f4, 12'h1a1, 12'h165, 12'h139};
   localparam logic [11:0] PWR_MV [8] = '{12'h9c4, 12'h7d0, 12'h683, 12'h4e2,
                                         12'h3e8, 12'h341, 12'h2ca, 12'h271};
   localparam logic [13:0] PCT [8] = '{14'h2710, 14'h1f40, 14'h1a0b, 14'h1388,
                                      14'h0fa0, 14'h0d05, 14'h0b29, 14'h09c4};
   sequence s_wr_ok; wr_strobe && addr == CRS_ADDR_RANGE && upper_password_level; endsequence
   sequence s_wr_deny; wr_strobe && addr == CRS_ADDR_RANGE && !upper_password_level; endsequence
   sequence s_rd_deny; rd_strobe && addr == CRS_ADDR_RANGE && !upper_password_level; endsequence
   sequence s_wr_loss; wr_strobe && addr == CRS_ADDR_LOSS && upper_password_level; endsequence
   property p_commit; s_wr_ok |=> nv_commit && !nv_commit_sel
      && nv_commit_data == ($past(wr_data) & 8'h77);
   endproperty
   a_commit: assert property (p_commit) else $error("commit data wrong");
   property p_commit_loss; s_wr_loss |=> nv_commit && nv_commit_sel
      && nv_commit_data == ($past(wr_data) & 8'h07);
   endproperty
   a_commit_loss: assert property (p_commit_loss) else $error("loss commit wrong");
   // read data stand one cycle only, zero otherwise
   property p_rd_idle; !rd_strobe |=> rd_data == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
   property p_no_commit; s_wr_deny |=> !nv_commit; endproperty
   a_no_commit: assert property (p_no_commit) else $error("denied write committed");
   property p_fields; s_wr_ok |=> ##1
      {1'b0, drive_current_range, 1'b0, power_loop_range} == ($past(wr_data, 2) & 8'h77);
   endproperty
   a_fields: assert property (p_fields) else $error("field outputs wrong");
   property p_rd_deny; s_rd_deny |=> rd_data == 8'h00; endproperty
   a_rd_deny: assert property (p_rd_deny) else $error("denied read leaked data");
   property p_resv; rd_strobe |=> (rd_data & 8'h88) == 8'h00; endproperty
   a_resv: assert property (p_resv) else $error("reserved bits read nonzero");
   property p_dflt; $rose(reset_n) |-> drive_current_range == 3'h0 && power_loop_range == 3'h0;
   endproperty
   a_dflt: assert property (p_dflt) else $error("range defaults wrong");
   property p_drv_fs; drive_current_fs_mv == DRV_MV[drive_current_range]
      && range_percent == PCT[drive_current_range]; endproperty
   a_drv_fs: assert property (p_drv_fs) else $error("drive full scale wrong");
   property p_pwr_fs; power_loop_fs_mv == PWR_MV[power_loop_range]; endproperty
   a_pwr_fs: assert property (p_pwr_fs) else $error("power full scale wrong");
   property p_los_fs; loss_low_fs_mv == DRV_MV[loss_low_range]; endproperty
   a_los_fs: assert property (p_los_fs) else $error("loss full scale wrong");
endmodule
bind crs_range crs_range_sva crs_range_sva_i (.mclk, .reset_n, .addr, .wr_data, .wr_strobe,
   .rd_strobe, .rd_data, .upper_password_level, .nv_commit, .nv_commit_sel, .nv_commit_data,
   .drive_current_range, .power_loop_range, .loss_low_range, .drive_current_fs_mv,
   .power_loop_fs_mv, .loss_low_fs_mv, .range_percent);
`default_nettype wire

//--- verification/crs_range_tb.sv
// testbench: self-checking bench for the comparator range bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
   import crs_pkg::*;
   logic       mclk = 1'b0;
   logic       reset_n = 1'b0;
   logic       wr_strobe = 1'b0;
   logic       rd_strobe = 1'b0;
   logic       pw = 1'b0;
   logic       rs_valid = 1'b0;
   logic       rs_sel = 1'b0;
   logic       rd_seen = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdat = 8'h00;
   logic [7:0] rs_data = 8'h00;
   logic [7:0] rd_data;
   logic [7:0] exp_rng;
   logic [7:0] e;
   logic [7:0] d;
   logic       p;
   logic [7:0] exp_q[$];
   logic [2:0] drv;
   logic [2:0] pwr;
   logic [2:0] los;
   int         failures = 0;
   int         tests_run = 0;
   crs_range crs_range_i (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wr_data(wdat),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
      .upper_password_level(pw), .nv_restore_valid(rs_valid), .nv_restore_sel(rs_sel),
      .nv_restore_data(rs_data), .nv_commit(), .nv_commit_sel(), .nv_commit_data(),
      .drive_current_range(drv), .power_loop_range(pwr), .loss_low_range(los),
      .drive_current_fs_mv(), .power_loop_fs_mv(), .loss_low_fs_mv(), .range_percent());
   always #20 mclk = ~mclk;
   // one bus cycle; a read notes its expected byte for the monitor
   task automatic bus(input logic w, r, input logic [7:0] a, v, input logic pl);
      addr <= a;
      wdat <= v;
      pw <= pl;
      wr_strobe <= w;
      rd_strobe <= r;
      if (r) exp_q.push_back(v);
      @(posedge mclk);
   endtask
   task automatic idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
   endtask
   task automatic restore(input logic s, input logic [7:0] v);
      rs_valid <= 1'b1;
      rs_sel <= s;
      rs_data <= v;
      idle(1);
      rs_valid <= 1'b0;
   endtask
   // outputs lag storage by one edge; look mid-cycle, resume on a rising edge
   task automatic fields(input logic [2:0] dc, pc, lc);
      idle(1);
      @(negedge mclk);
      `CHK(drv, dc)
      `CHK(pwr, pc)
      `CHK(los, lc)
      @(posedge mclk);
   endtask
   always @(posedge mclk) rd_seen <= rd_strobe;
   always @(negedge mclk) begin
      if (rd_seen) begin
         e = exp_q.pop_front();
         `CHK(rd_data, e)
      end
   end
   task automatic print_verdict();
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #400000;
      failures++;
      print_verdict();
   end
   initial begin
      void'($urandom(93622));
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      fields(3'h0, 3'h0, 3'h0);
      bus(1'b0, 1'b1, CRS_ADDR_RANGE, 8'h00, 1'b1);
      // every code, reserved bits written high
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, 1'b0, CRS_ADDR_RANGE, {1'b1, 3'(c), 1'b1, 3'(7 - c)}, 1'b1);
         bus(1'b1, 1'b0, CRS_ADDR_LOSS, {5'h1f, 3'(c)}, 1'b1);
         bus(1'b0, 1'b1, CRS_ADDR_RANGE, {1'b0, 3'(c), 1'b0, 3'(7 - c)}, 1'b1);
         fields(3'(c), 3'(7 - c), 3'(c));
      end
      exp_rng = 8'h70;
      for (int i = 0; i < 24; i++) begin
         d = 8'($urandom);
         p = 1'($urandom);
         bus(1'b1, 1'b0, CRS_ADDR_RANGE, d, p);
         if (p) exp_rng = d & CRS_RANGE_MASK;
         bus(1'b0, 1'b1, CRS_ADDR_RANGE, exp_rng, 1'b1);
         bus(1'b0, 1'b1, CRS_ADDR_RANGE, 8'h00, 1'b0);
      end
      bus(1'b0, 1'b1, 8'h10, 8'h00, 1'b1);
      d = 8'($urandom);
      restore(CRS_IDX_RANGE, d);
      bus(1'b0, 1'b1, CRS_ADDR_RANGE, d & CRS_RANGE_MASK, 1'b1);
      restore(CRS_IDX_LOSS, 8'hfa);
      fields(d[6:4], d[2:0], 3'h2);
      // reset in mid-run returns the factory default
      reset_n <= 1'b0;
      idle(2);
      reset_n <= 1'b1;
      idle(1);
      bus(1'b0, 1'b1, CRS_ADDR_RANGE, 8'h00, 1'b1);
      fields(3'h0, 3'h0, 3'h0);
      // status: denied write and read, a commit, then clear by ones at the upper level
      bus(1'b0, 1'b1, CRS_ADDR_STATUS, 8'h00, 1'b0);
      bus(1'b1, 1'b0, CRS_ADDR_RANGE, 8'h55, 1'b0);
      bus(1'b0, 1'b1, CRS_ADDR_RANGE, 8'h00, 1'b0);
      bus(1'b1, 1'b0, CRS_ADDR_RANGE, 8'hff, 1'b1);
      bus(1'b0, 1'b1, CRS_ADDR_STATUS, 8'h07, 1'b0);
      bus(1'b1, 1'b0, CRS_ADDR_STATUS, 8'h03, 1'b1);
      // clear without the password level is ignored
      bus(1'b1, 1'b0, CRS_ADDR_STATUS, 8'h04, 1'b0);
      bus(1'b0, 1'b1, CRS_ADDR_STATUS, 8'h04, 1'b0);
      fields(3'h7, 3'h7, 3'h0);
      idle(2);
      print_verdict();
   end
endmodule
`default_nettype wire

//--- verilog/crs_nv_store.sv
// module: two-word range storage with a registered read port
`timescale 1ns/1ps
`default_nettype none
module crs_nv_store
   import crs_pkg::*;
#(
   parameter int DW = 8
) (
   input  wire logic          mclk,
   input  wire logic          reset_n,
   input  wire logic          wr_en,
   input  wire logic          wr_idx,
   input  wire logic [DW-1:0] wr_data,
   input  wire logic          rd_en,
   input  wire logic          rd_idx,
   output logic      [DW-1:0] rd_q,
   output logic      [DW-1:0] word0,
   output logic      [DW-1:0] word1
);
   import crs_pkg::*;

   logic [DW-1:0] mem [0:1];

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mem[0] <= DW'(CRS_RANGE_RESET);
         mem[1] <= DW'(CRS_LOSS_RESET);
      end else if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // read data hold only in the cycle after the read
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rd_q <= '0;
      end else if (rd_en) begin
         rd_q <= mem[rd_idx];
      end else begin
         rd_q <= '0;
      end
   end

   assign word0 = mem[0];
   assign word1 = mem[1];
endmodule
`default_nettype wire

//--- verilog/crs_pkg.sv
// package: offsets, field layout and reset values of the comparator range registers
package crs_pkg;
   localparam int          CRS_AW              = 8;
   localparam int          CRS_DW              = 8;
   localparam int          CRS_CW              = 3;
   localparam int          CRS_MW              = 12;
   localparam int          CRS_PW              = 14;
   // register byte addresses
   localparam logic [7:0]  CRS_ADDR_RANGE      = 8'hb9;
   localparam logic [7:0]  CRS_ADDR_LOSS       = 8'hf0;
   localparam logic [7:0]  CRS_ADDR_STATUS     = 8'hf1;
   // field positions
   localparam int          CRS_DRIVE_LSB       = 4;
   localparam int          CRS_POWER_LSB       = 0;
   localparam int          CRS_LOSS_LSB        = 0;
   localparam int          CRS_ST_WDENY        = 0;
   localparam int          CRS_ST_RDENY        = 1;
   localparam int          CRS_ST_COMMIT       = 2;
   // writable bit masks, reserved bits stay zero
   localparam logic [7:0]  CRS_RANGE_MASK      = 8'h77;
   localparam logic [7:0]  CRS_LOSS_MASK       = 8'h07;
   localparam logic [7:0]  CRS_STATUS_MASK     = 8'h07;
   // factory defaults
   localparam logic [7:0]  CRS_RANGE_RESET     = 8'h00;
   localparam logic [7:0]  CRS_LOSS_RESET      = 8'h00;
   localparam logic [7:0]  CRS_STATUS_RESET    = 8'h00;
   // storage word indices
   localparam logic        CRS_IDX_RANGE       = 1'b0;
   localparam logic        CRS_IDX_LOSS        = 1'b1;
   // full-scale bases in millivolts
   localparam logic [11:0] CRS_DRIVE_BASE_MV   = 12'h4e2;
   localparam logic [11:0] CRS_POWER_BASE_MV   = 12'h9c4;
   localparam logic [11:0] CRS_LOSS_BASE_MV    = 12'h4e2;

   typedef enum logic [1:0] {
      CRS_SRC_NONE   = 2'b00,
      CRS_SRC_STORE  = 2'b01,
      CRS_SRC_STATUS = 2'b10
   } crs_src_t;
endpackage

//--- verilog/crs_range.sv
// module: comparator range select register bank and full-scale decode
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module crs_range
   import crs_pkg::*;
(
   input  wire logic                   mclk,
   input  wire logic                   reset_n,
   input  wire logic [crs_pkg::CRS_AW-1:0] addr,
   input  wire logic [crs_pkg::CRS_DW-1:0] wr_data,
   input  wire logic                   wr_strobe,
   input  wire logic                   rd_strobe,
   output logic      [crs_pkg::CRS_DW-1:0] rd_data,
   input  wire logic                   upper_password_level,
   input  wire logic                   nv_restore_valid,
   input  wire logic                   nv_restore_sel,
   input  wire logic [crs_pkg::CRS_DW-1:0] nv_restore_data,
   output logic                        nv_commit,
   output logic                        nv_commit_sel,
   output logic      [crs_pkg::CRS_DW-1:0] nv_commit_data,
   output logic      [crs_pkg::CRS_CW-1:0] drive_current_range,
   output logic      [crs_pkg::CRS_CW-1:0] power_loop_range,
   output logic      [crs_pkg::CRS_CW-1:0] loss_low_range,
   output logic      [crs_pkg::CRS_MW-1:0] drive_current_fs_mv,
   output logic      [crs_pkg::CRS_MW-1:0] power_loop_fs_mv,
   output logic      [crs_pkg::CRS_MW-1:0] loss_low_fs_mv,
   output logic      [crs_pkg::CRS_PW-1:0] range_percent
);
   import crs_pkg::*;

   // percent of full scale, in hundredths, per range code
   function automatic logic [CRS_PW-1:0] pct_of(input logic [CRS_CW-1:0] code);
      case (code)
         3'h0:    pct_of = 14'h2710;
         3'h1:    pct_of = 14'h1f40;
         3'h2:    pct_of = 14'h1a0b;
         3'h3:    pct_of = 14'h1388;
         3'h4:    pct_of = 14'h0fa0;
         3'h5:    pct_of = 14'h0d05;
         3'h6:    pct_of = 14'h0b29;
         3'h7:    pct_of = 14'h09c4;
         default: pct_of = 14'h2710;
      endcase
   endfunction

   // full scale in millivolts; table beats division by 1/n for rounding
   function automatic logic [CRS_MW-1:0] fs_mv(input logic [CRS_MW-1:0] base,
                                                input logic [CRS_CW-1:0] code);
      logic wide;
      wide = (base == CRS_POWER_BASE_MV);
      case (code)
         3'h0:    fs_mv = base;
         3'h1:    fs_mv = wide ? 12'h7d0 : 12'h3e8;
         3'h2:    fs_mv = wide ? 12'h683 : 12'h341;
         3'h3:    fs_mv = wide ? 12'h4e2 : 12'h271;
         3'h4:    fs_mv = wide ? 12'h3e8 : 12'h1f4;
         3'h5:    fs_mv = wide ? 12'h341 : 12'h1a1;
         3'h6:    fs_mv = wide ? 12'h2ca : 12'h165;
         3'h7:    fs_mv = wide ? 12'h271 : 12'h139;
         default: fs_mv = base;
      endcase
   endfunction

   logic                hit_range;
   logic                hit_loss;
   logic                hit_status;
   logic                allowed;
   logic                store_wr;
   logic                store_wr_idx;
   logic [CRS_DW-1:0]   store_wr_data;
   logic                store_rd;
   logic [CRS_DW-1:0]   store_rd_q;
   logic [CRS_DW-1:0]   word_range;
   logic [CRS_DW-1:0]   word_loss;
   logic                sw_wr;
   logic [CRS_DW-1:0]   status;
   logic [CRS_DW-1:0]   status_rd_q;
   crs_src_t            rd_src;
   logic                set_wdeny;
   logic                set_rdeny;

   assign hit_range  = (addr == CRS_ADDR_RANGE);
   assign hit_loss   = (addr == CRS_ADDR_LOSS);
   assign hit_status = (addr == CRS_ADDR_STATUS);
   assign allowed    = upper_password_level;

   // software write wins over a restore in the same cycle
   assign sw_wr = wr_strobe && (hit_range || hit_loss) && allowed;

   always_comb begin
      store_wr      = 1'b0;
      store_wr_idx  = CRS_IDX_RANGE;
      store_wr_data = '0;
      if (sw_wr) begin
         store_wr      = 1'b1;
         store_wr_idx  = hit_loss ? CRS_IDX_LOSS : CRS_IDX_RANGE;
         store_wr_data = wr_data & (hit_loss ? CRS_LOSS_MASK : CRS_RANGE_MASK);
      end else if (nv_restore_valid) begin
         store_wr      = 1'b1;
         store_wr_idx  = nv_restore_sel;
         store_wr_data = nv_restore_data
                         & (nv_restore_sel ? CRS_LOSS_MASK : CRS_RANGE_MASK);
      end
   end

   // denied reads return zero, not stale storage
   assign store_rd  = rd_strobe && (hit_range || hit_loss) && allowed;
   assign set_wdeny = wr_strobe && (hit_range || hit_loss) && !allowed;
   assign set_rdeny = rd_strobe && (hit_range || hit_loss) && !allowed;

   crs_nv_store #(
      .DW (CRS_DW)
   ) u_store (
      .mclk    (mclk),
      .reset_n (reset_n),
      .wr_en   (store_wr),
      .wr_idx  (store_wr_idx),
      .wr_data (store_wr_data),
      .rd_en   (store_rd),
      .rd_idx  (hit_loss),
      .rd_q    (store_rd_q),
      .word0   (word_range),
      .word1   (word_loss)
   );

   // persistence hand-off: each accepted range or loss write is pushed to the nv engine
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         nv_commit      <= 1'b0;
         nv_commit_sel  <= 1'b0;
         nv_commit_data <= '0;
      end else begin
         nv_commit      <= sw_wr;
         nv_commit_sel  <= hit_loss;
         nv_commit_data <= sw_wr ? store_wr_data : '0;
      end
   end

   // sticky status; hardware set wins over software clear
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         status <= CRS_STATUS_RESET;
      end else begin
         if (wr_strobe && hit_status && allowed) begin
            status <= status & ~(wr_data & CRS_STATUS_MASK);
         end
         if (set_wdeny) begin
            status[CRS_ST_WDENY] <= 1'b1;
         end
         if (set_rdeny) begin
            status[CRS_ST_RDENY] <= 1'b1;
         end
         if (sw_wr) begin
            status[CRS_ST_COMMIT] <= 1'b1;
         end
      end
   end

   // status readable at any password level
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         status_rd_q <= '0;
         rd_src      <= CRS_SRC_NONE;
      end else begin
         status_rd_q <= (rd_strobe && hit_status) ? status : '0;
         if (store_rd) begin
            rd_src <= CRS_SRC_STORE;
         end else if (rd_strobe && hit_status) begin
            rd_src <= CRS_SRC_STATUS;
         end else begin
            rd_src <= CRS_SRC_NONE;
         end
      end
   end

   always_comb begin
      case (rd_src)
         CRS_SRC_STORE:  rd_data = store_rd_q;
         CRS_SRC_STATUS: rd_data = status_rd_q;
         CRS_SRC_NONE:   rd_data = '0;
         default:        rd_data = '0;
      endcase
   end

   // field outputs and decoded full scale, registered
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         drive_current_range <= CRS_RANGE_RESET[CRS_DRIVE_LSB +: CRS_CW];
         power_loop_range    <= CRS_RANGE_RESET[CRS_POWER_LSB +: CRS_CW];
         loss_low_range      <= CRS_LOSS_RESET[CRS_LOSS_LSB +: CRS_CW];
      end else begin
         drive_current_range <= word_range[CRS_DRIVE_LSB +: CRS_CW];
         power_loop_range    <= word_range[CRS_POWER_LSB +: CRS_CW];
         loss_low_range      <= word_loss[CRS_LOSS_LSB +: CRS_CW];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         drive_current_fs_mv <= CRS_DRIVE_BASE_MV;
         power_loop_fs_mv    <= CRS_POWER_BASE_MV;
         loss_low_fs_mv      <= CRS_LOSS_BASE_MV;
         range_percent       <= 14'h2710;
      end else begin
         drive_current_fs_mv <= fs_mv(CRS_DRIVE_BASE_MV,
                                      word_range[CRS_DRIVE_LSB +: CRS_CW]);
         power_loop_fs_mv    <= fs_mv(CRS_POWER_BASE_MV,
                                      word_range[CRS_POWER_LSB +: CRS_CW]);
         loss_low_fs_mv      <= fs_mv(CRS_LOSS_BASE_MV,
                                      word_loss[CRS_LOSS_LSB +: CRS_CW]);
         range_percent       <= pct_of(word_range[CRS_DRIVE_LSB +: CRS_CW]);
      end
   end
endmodule
`default_nettype wire
